// ### pkg/spi_ctrl_pkg.sv
/*
 * Constants, field layouts, carrier structs and state codes for the byte-wide
 * serial controller/peripheral block with its Wishbone register slave.
 * Assumes one bus clock and a synchronous active-high reset.
 */
// Functional notes
// R1 - Receive-full or mode-fault raises the interrupt when its enable bit is set
// R2 - Clearing enable aborts the transfer, flushes buffers, resets state machines
// R3 - On disable receive-full clears and transmit-empty sets
// R4 - Transmit-empty raises the interrupt when the transmit interrupt enable is set
// R5 - Role bit: 0 selects peripheral, 1 selects controller
// R6 - Polarity bit inverts the serial clock; 0 idles low, 1 idles high
// R7 - Phase 0: first clock edge mid bit; phase 1: edge at bit start
// R8 - Bit order: 0 sends most significant bit first, 1 least significant
// R9 - Controller without fault detect leaves the select pin untouched
// R10 - Controller with fault detect: select pin is fault input or auto select output
// R11 - In peripheral role the select pin is always the select input
// R12 - Single-wire mode: bidir enable turns the shared data driver on or off
// R13 - Without single-wire mode the bidir enable has no effect
// R14 - Single-wire uses controller-out pin as controller, controller-in pin as peripheral
// R15 - Wait-stop bit halts the block clocks while the processor waits
// R16 - Unimplemented bits 7, 6, 5 and 2 of control two read zero
// R17 - Software keeps disable and phase change in separate writes
// R18 - Peripheral takes part only while the select input is low
// R19 - Bit clock is bus clock over prescale 1..8 times power-of-two 2..256
// R20 - Transmit-empty sets whenever a byte moves into the shift register
// R21 - Low select input in controller fault-input mode sets the mode-fault flag
// R22 - Automatic select output is low during each controller transfer, high between
package spi_ctrl_pkg;

  // ---------------------------------------------------------------------------
  // Register byte addresses
  // ---------------------------------------------------------------------------
  localparam int unsigned ADR_W = 5;
  localparam logic [ADR_W-1:0] ADR_CTRL1  = 5'h00;
  localparam logic [ADR_W-1:0] ADR_CTRL2  = 5'h04;
  localparam logic [ADR_W-1:0] ADR_BAUD   = 5'h08;
  localparam logic [ADR_W-1:0] ADR_STATUS = 5'h0C;
  localparam logic [ADR_W-1:0] ADR_DATA   = 5'h10;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int unsigned C1_RFIE = 7;
  localparam int unsigned C1_EN   = 6;
  localparam int unsigned C1_TXIE = 5;
  localparam int unsigned C1_CTRL = 4;
  localparam int unsigned C1_CLOCK_IDLE_LEVEL = 3;
  localparam int unsigned C1_CLOCK_PHASE_SELECT = 2;
  localparam int unsigned C1_SELOUT = 1;
  localparam int unsigned C1_LSBF = 0;
  localparam int unsigned C2_FDEN = 4;
  localparam int unsigned C2_BIDIR = 3;
  localparam int unsigned C2_WSTOP = 1;
  localparam int unsigned C2_SWIRE = 0;
  localparam int unsigned ST_RXF  = 7;
  localparam int unsigned ST_TXE  = 5;
  localparam int unsigned ST_FAULT = 4;

  // ---------------------------------------------------------------------------
  // Masks, reset values and counts
  // ---------------------------------------------------------------------------
  localparam logic [7:0] C2_MASK    = 8'h1B;
  localparam logic [7:0] BAUD_MASK  = 8'h77;
  localparam logic [7:0] CTRL1_RST  = 8'h00;
  localparam logic [7:0] CTRL2_RST  = 8'h00;
  localparam logic [7:0] BAUD_RST   = 8'h00;
  localparam logic [4:0] EDGE_LAST  = 5'h10;

  // ---------------------------------------------------------------------------
  // Carriers and states
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic             cyc;
    logic             stb;
    logic             we;
    logic [ADR_W-1:0] adr;
    logic [3:0]       sel;
    logic [31:0]      dat;
  } wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_t;

  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic ss;
  } pin_in_t;

  typedef struct packed {
    logic sck;
    logic sck_oe_n;
    logic mosi;
    logic mosi_oe_n;
    logic miso;
    logic miso_oe_n;
    logic ss;
    logic ss_oe_n;
  } pin_out_t;

  typedef enum logic [1:0] {
    XS_IDLE  = 2'b01,
    XS_SHIFT = 2'b10
  } xfer_state_t;

endpackage

// ### src/spi_ctrl.sv
/*
 * Byte-wide serial controller/peripheral with its control registers,
 * flags, baud divider, shifter and pin multiplexing, reached over a
 * classic Wishbone slave. Pins are split into in/out/enable triples;
 * the surroundings resolve the wires. Pin inputs are synchronous to clk_i.
 */
// Added by the designer: register access over Wishbone and the register offsets.
`timescale 1ns/100ps
module spi_ctrl (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  spi_ctrl_pkg::wb_req_t  wb_i,
  output spi_ctrl_pkg::wb_rsp_t  wb_o,
  input  wire logic              wait_mode_i,
  input  spi_ctrl_pkg::pin_in_t  pin_i,
  output spi_ctrl_pkg::pin_out_t pin_o,
  output logic                   irq_o
);
  import spi_ctrl_pkg::*;

  // ---------------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------------
  logic [7:0]  ctrl1_ff;
  logic [7:0]  ctrl2_ff;
  logic [7:0]  baud_ff;
  logic [7:0]  tx_buf_ff;
  logic [7:0]  rx_buf_ff;
  logic [7:0]  shift_ff;
  logic        rx_full_ff;
  logic        tx_empty_ff;
  logic        mode_fault_ff;
  logic        rx_arm_ff;
  logic        tx_arm_ff;
  logic        mf_arm_ff;
  logic        ack_ff;
  logic [31:0] rdat_ff;
  xfer_state_t state_ff;
  logic [4:0]  edge_cnt_ff;
  logic        sck_act_ff;
  logic        sin_ff;
  logic        sck_prev_ff;
  logic        sel_prev_ff;
  logic        sel_hold_ff;
  logic [2:0]  pre_cnt_ff;
  logic [7:0]  rate_cnt_ff;

  logic       en;
  logic       controller;
  logic       clock_idle_level;
  logic       clock_phase_select;
  logic       lsbf;
  logic       auto_sel;
  logic       fden;
  logic       swire;
  logic       bidir;
  logic       run;
  logic       sel;
  logic       busy;
  logic       req;
  logic       acc;
  logic       wr;
  logic       rd;
  logic [7:0] rate_top;
  logic       half_tick;
  logic       sck_edge;
  logic       edge_evt;
  logic [4:0] k;
  logic       is_sample;
  logic       is_shift;
  logic       done;
  logic       start_c;
  logic       start_p;
  logic       load_evt;
  logic       mf_hit;
  logic       abort;
  logic       din;
  logic       sdo;
  logic       final_bit;
  logic [7:0] rd_val;

  function automatic logic hit(input logic [ADR_W-1:0] adr, input logic [ADR_W-1:0] off);
    return adr == off;
  endfunction

  function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b,
                                          input logic lsb_first);
    return lsb_first ? {b, v[7:1]} : {v[6:0], b};
  endfunction

  assign en         = ctrl1_ff[C1_EN];
  assign controller = ctrl1_ff[C1_CTRL];                          // R5
  assign clock_idle_level       = ctrl1_ff[C1_CLOCK_IDLE_LEVEL];
  assign clock_phase_select       = ctrl1_ff[C1_CLOCK_PHASE_SELECT];
  assign lsbf       = ctrl1_ff[C1_LSBF];
  assign auto_sel   = ctrl1_ff[C1_SELOUT];
  assign fden       = ctrl2_ff[C2_FDEN];
  assign swire      = ctrl2_ff[C2_SWIRE];
  assign bidir      = ctrl2_ff[C2_BIDIR];
  assign run        = ~(wait_mode_i & ctrl2_ff[C2_WSTOP]);        // R15
  assign sel        = ~pin_i.ss;                                  // R18
  assign busy       = state_ff == XS_SHIFT;

  // ---------------------------------------------------------------------------
  // Wishbone slave: ack one cycle after the request, access at the ack edge
  // ---------------------------------------------------------------------------
  assign req = wb_i.cyc & wb_i.stb & ~ack_ff;
  assign acc = wb_i.cyc & wb_i.stb & ack_ff;
  assign wr  = acc & wb_i.we & wb_i.sel[0];
  assign rd  = acc & ~wb_i.we;

  always_comb begin
    rd_val = 8'h00;
    if (hit(wb_i.adr, ADR_CTRL1)) rd_val = ctrl1_ff;
    else if (hit(wb_i.adr, ADR_CTRL2)) rd_val = ctrl2_ff & C2_MASK;   // R16
    else if (hit(wb_i.adr, ADR_BAUD)) rd_val = baud_ff & BAUD_MASK;
    else if (hit(wb_i.adr, ADR_STATUS)) rd_val = {rx_full_ff, 1'b0, tx_empty_ff,
                                                 mode_fault_ff, 4'h0};
    else if (hit(wb_i.adr, ADR_DATA)) rd_val = rx_buf_ff;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff  <= 1'b0;
      rdat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= req;
      if (req) rdat_ff <= {24'h00_0000, rd_val};
    end
  end

  assign wb_o = '{ack: ack_ff, dat: rdat_ff};

  // ---------------------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl1_ff <= CTRL1_RST;
      ctrl2_ff <= CTRL2_RST;
      baud_ff  <= BAUD_RST;
    end else begin
      if (wr && hit(wb_i.adr, ADR_CTRL1)) ctrl1_ff <= wb_i.dat[7:0];
      if (wr && hit(wb_i.adr, ADR_CTRL2)) ctrl2_ff <= wb_i.dat[7:0] & C2_MASK;  // R16
      if (wr && hit(wb_i.adr, ADR_BAUD)) baud_ff <= wb_i.dat[7:0] & BAUD_MASK;
      // A fault drops controller role so two controllers stop fighting
      if (mf_hit) ctrl1_ff[C1_CTRL] <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Baud divider: half-bit pulse every (prescale) x (rate/2) bus cycles
  // ---------------------------------------------------------------------------
  assign rate_top  = 8'((9'h001 << baud_ff[2:0]) - 9'h001);     // R19
  assign half_tick = busy & controller & run & (pre_cnt_ff == baud_ff[6:4])
                     & (rate_cnt_ff == rate_top);              // R19

  always_ff @(posedge clk_i) begin
    if (rst_i || !en || !busy) begin
      pre_cnt_ff  <= 3'h0;
      rate_cnt_ff <= 8'h00;
    end else if (run) begin
      if (pre_cnt_ff == baud_ff[6:4]) begin
        pre_cnt_ff  <= 3'h0;
        rate_cnt_ff <= (rate_cnt_ff == rate_top) ? 8'h00 : rate_cnt_ff + 8'h01;
      end else begin
        pre_cnt_ff <= pre_cnt_ff + 3'h1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Edge sequencing shared by both roles: 16 clock edges per byte
  // ---------------------------------------------------------------------------
  assign sck_edge  = run & ~controller & sel & (pin_i.sck ^ sck_prev_ff);
  assign edge_evt  = en & busy & (controller ? half_tick : sck_edge);
  assign k         = edge_cnt_ff + 5'h01;
  assign is_sample = k[0] ^ clock_phase_select;                                  // R7
  assign is_shift  = ~is_sample & (k > 5'h01) & (k < EDGE_LAST);   // R7
  assign done      = edge_evt & (k == EDGE_LAST);
  assign start_c   = en & controller & ~busy & ~tx_empty_ff & ~mf_hit & ~sel_hold_ff;  // R22
  assign start_p   = en & ~controller & ~busy & sel & ~sel_prev_ff & run;  // R18
  assign load_evt  = ~tx_empty_ff & (start_c | start_p | (done & ~controller));
  assign mf_hit    = en & controller & fden & ~auto_sel & ~pin_i.ss;  // R21
  assign abort     = ~en | mf_hit | (~controller & ~sel & busy);   // R2 R18

  always_ff @(posedge clk_i) begin
    if (rst_i || abort) begin                                      // R2
      state_ff    <= XS_IDLE;
      edge_cnt_ff <= 5'h00;
    end else begin
      case (state_ff)
        XS_IDLE: begin
          edge_cnt_ff <= 5'h00;
          if (start_c || start_p) state_ff <= XS_SHIFT;
        end
        XS_SHIFT: begin
          if (edge_evt) edge_cnt_ff <= done ? 5'h00 : k;
          // Controller rests two cycles between bytes; peripheral stays selected
          if (done && controller) state_ff <= XS_IDLE;
        end
        default: state_ff <= XS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sck_prev_ff <= 1'b0;
      sel_prev_ff <= 1'b0;
    end else if (run) begin
      sck_prev_ff <= pin_i.sck;
      sel_prev_ff <= sel;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || abort || !busy) sck_act_ff <= 1'b0;
    else if (edge_evt && controller) sck_act_ff <= ~sck_act_ff;    // R7
  end

  // Select stays low one cycle past the last edge so the peer still sees it selected
  always_ff @(posedge clk_i) begin
    if (rst_i || abort) sel_hold_ff <= 1'b0;
    else sel_hold_ff <= done & controller;                         // R22
  end

  // ---------------------------------------------------------------------------
  // Shifter and data buffers
  // ---------------------------------------------------------------------------
  assign din = controller ? (swire ? pin_i.mosi : pin_i.miso)      // R14
                          : (swire ? pin_i.miso : pin_i.mosi);     // R14
  assign sdo       = lsbf ? shift_ff[0] : shift_ff[7];             // R8
  assign final_bit = clock_phase_select ? din : sin_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i || !en) begin                                        // R2
      shift_ff  <= 8'h00;
      sin_ff    <= 1'b0;
      rx_buf_ff <= 8'h00;
    end else begin
      if (load_evt) shift_ff <= tx_buf_ff;
      else if (edge_evt && is_shift) shift_ff <= shift_in(shift_ff, sin_ff, lsbf);  // R8
      if (edge_evt && is_sample) sin_ff <= din;
      if (done) rx_buf_ff <= shift_in(shift_ff, final_bit, lsbf);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !en) tx_buf_ff <= 8'h00;                          // R2
    else if (wr && hit(wb_i.adr, ADR_DATA) && tx_arm_ff) tx_buf_ff <= wb_i.dat[7:0];
  end

  // ---------------------------------------------------------------------------
  // Flags: a status read with the flag set arms its clearing access
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i || !en) begin                                        // R3
      rx_full_ff <= 1'b0;
      rx_arm_ff  <= 1'b0;
    end else begin
      if (done) rx_full_ff <= 1'b1;
      else if (rd && hit(wb_i.adr, ADR_DATA) && rx_arm_ff) rx_full_ff <= 1'b0;
      if (rd && hit(wb_i.adr, ADR_STATUS)) rx_arm_ff <= rdat_ff[ST_RXF];
      else if (rd && hit(wb_i.adr, ADR_DATA)) rx_arm_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !en) begin                                        // R3
      tx_empty_ff <= 1'b1;
      tx_arm_ff   <= 1'b0;
    end else begin
      if (load_evt) tx_empty_ff <= 1'b1;                           // R20
      else if (wr && hit(wb_i.adr, ADR_DATA) && tx_arm_ff) tx_empty_ff <= 1'b0;
      if (rd && hit(wb_i.adr, ADR_STATUS)) tx_arm_ff <= rdat_ff[ST_TXE];
      else if (wr && hit(wb_i.adr, ADR_DATA)) tx_arm_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !en) begin
      mode_fault_ff <= 1'b0;
      mf_arm_ff     <= 1'b0;
    end else begin
      if (mf_hit) mode_fault_ff <= 1'b1;                           // R21
      else if (wr && hit(wb_i.adr, ADR_CTRL1) && mf_arm_ff) mode_fault_ff <= 1'b0;
      if (rd && hit(wb_i.adr, ADR_STATUS)) mf_arm_ff <= rdat_ff[ST_FAULT];
      else if (wr && hit(wb_i.adr, ADR_CTRL1)) mf_arm_ff <= 1'b0;
    end
  end

  assign irq_o = (ctrl1_ff[C1_RFIE] & (rx_full_ff | mode_fault_ff))   // R1
               | (ctrl1_ff[C1_TXIE] & tx_empty_ff);                   // R4

  // ---------------------------------------------------------------------------
  // Pin multiplexing; enables are active low
  // ---------------------------------------------------------------------------
  always_comb begin
    pin_o.sck       = sck_act_ff ^ clock_idle_level;                               // R6
    pin_o.sck_oe_n  = ~(en & controller);                              // R5
    pin_o.mosi      = sdo;
    pin_o.mosi_oe_n = ~(en & controller & (~swire | bidir));           // R12 R13 R14
    pin_o.miso      = sdo;
    pin_o.miso_oe_n = ~(en & ~controller & sel & (~swire | bidir));    // R11 R12 R13
    pin_o.ss        = ~(busy | sel_hold_ff);                           // R22
    pin_o.ss_oe_n   = ~(en & controller & fden & auto_sel);            // R9 R10
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_load;
    load_evt;
  endsequence

  sequence s_byte_done;
    done ##1 rx_full_ff;
  endsequence

  AST_RX_IRQ: assert property (ctrl1_ff[C1_RFIE] && done |=> irq_o)  // R1
    else $error("receive-full did not raise the interrupt");
  AST_DISABLE: assert property ($fell(en) |=> !busy && tx_empty_ff && !rx_full_ff)  // R2
    else $error("disable did not flush state and flags");
  AST_FLAGS_OFF: assert property (!en |=> tx_empty_ff && !rx_full_ff && !mode_fault_ff)  // R3
    else $error("flags wrong while disabled");
  AST_TX_IRQ: assert property (!ctrl1_ff[C1_TXIE] ##1 ctrl1_ff[C1_TXIE] && tx_empty_ff
                               |-> irq_o)  // R4
    else $error("transmit-empty interrupt missing");
  AST_SCK_IDLE: assert property (en && controller && !busy |-> pin_o.sck == clock_idle_level
                                 && !pin_o.sck_oe_n)  // R6
    else $error("controller clock not idle at polarity level");
  AST_BYTE_END: assert property (edge_evt && k == EDGE_LAST |-> s_byte_done)  // R7
    else $error("byte did not complete on the sixteenth edge");
  AST_FIRST_BIT: assert property (s_load |=> sdo == (lsbf ? $past(tx_buf_ff[0])
                                                         : $past(tx_buf_ff[7])))  // R8
    else $error("first bit out is not the selected end");
  AST_SS_GPIO: assert property (controller && !fden |-> pin_o.ss_oe_n)  // R9
    else $error("select pin driven without fault detect");
  AST_SS_AUTO: assert property (en && controller && fden && auto_sel && busy
                                |-> !pin_o.ss_oe_n && !pin_o.ss)  // R22
    else $error("automatic select not low during transfer");
  AST_FAULT_SET: assert property (en && controller && fden && !auto_sel && !pin_i.ss
                             |=> mode_fault_ff && !controller)  // R21
    else $error("mode fault not flagged");
  AST_BIDIR_OFF: assert property (swire && !bidir |-> pin_o.mosi_oe_n && pin_o.miso_oe_n)  // R12
    else $error("shared data pin driven with driver off");
  AST_WAIT_HOLD: assert property (busy && !run |=> $stable(edge_cnt_ff) && $stable(shift_ff))  // R15
    else $error("shifter moved while clocks stopped");
  AST_C2_ZERO: assert property (ack_ff && !wb_i.we && hit(wb_i.adr, ADR_CTRL2)
                                |-> (wb_o.dat[7:0] & 8'hE4) == 8'h00)  // R16
    else $error("unimplemented control bits read nonzero");
  AST_TXE_LOAD: assert property (s_load |=> tx_empty_ff)  // R20
    else $error("transmit-empty not set after load");

endmodule // spi_ctrl

// ### tb/spi_peer_model.sv
/* Behavioural peer on the far side of the serial link.
   Assumes the bench resolves the pins and the clock runs well below clk_i/4. */
`timescale 1ns/100ps
module spi_peer_model (
  input  wire logic       clk_i,
  input  wire logic       sel_n_i,
  input  wire logic       sck_i,
  input  wire logic       mosi_i,
  input  wire logic       clock_phase_select_i,
  input  wire logic       lsbf_i,
  input  wire logic [7:0] tx_byte_i,
  output logic            miso_o,
  output logic [7:0]      rx_byte_o
);
  logic       sck_q = 1'b0;
  logic       last = 1'b0;
  logic [2:0] idx = 3'h0;
  logic [4:0] cnt = 5'h00;
  logic [4:0] nxt_cnt;
  // Released line shows the inverse of its last level, never a stale copy
  assign miso_o  = sel_n_i ? ~last : tx_byte_i[lsbf_i ? idx : 3'h7 - idx];
  assign nxt_cnt = cnt + 5'h01;
  always @(posedge clk_i) begin
    sck_q <= sck_i;
    last  <= miso_o;
    if (sel_n_i) begin
      cnt <= 5'h00;
      idx <= 3'h0;
    end else if (sck_i !== sck_q) begin
      cnt <= nxt_cnt;
      if (nxt_cnt[0] ^ clock_phase_select_i)
        rx_byte_o <= lsbf_i ? {mosi_i, rx_byte_o[7:1]} : {rx_byte_o[6:0], mosi_i};
      else if (!clock_phase_select_i || nxt_cnt > 5'h02)
        idx <= idx + 3'h1;
    end
  end
endmodule // spi_peer_model

// ### tb/spi_control_configuration_tb.sv
/* Self-checking bench for spi_ctrl: Wishbone master, pin resolution, peer.
   Assumes a one-cycle ack and pin outputs decoded from flip-flops. */
`timescale 1ns/100ps
module spi_control_configuration_tb;
  import spi_ctrl_pkg::*;
  typedef struct packed {
    logic [7:0] c1;
    logic [7:0] c2;
    logic [7:0] c2_rd;
    logic [3:0] oe_n;
    logic       irq;
  } row_t;
  logic       clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       wait_mode = 1'b0;
  logic       ss_drv = 1'b1;
  logic       clock_phase_select = 1'b0;
  logic       lsbf = 1'b0;
  logic       sck_q = 1'b0;
  logic [7:0] peer_tx = 8'h00;
  logic [7:0] peer_rx;
  logic [7:0] rd;
  logic       peer_miso;
  logic       irq;
  logic [3:0] oe_now;
  wb_req_t    req = '0;
  wb_rsp_t    rsp;
  pin_in_t    pin_in;
  pin_out_t   pin_out;
  int         n_edge = 0;
  int         t_first = 0;
  int         t_last = 0;
  int         cyc_n = 0;
  int         n_fail = 0;
  int         checks = 0;
  row_t       rows [10];

  // ---------------------------------------------------------------
  // Pins and partner
  // ---------------------------------------------------------------
  always #25 clk_i = ~clk_i;
  // Undriven clock and controller-out lines rest on pull-ups; controller-in follows the peer, select follows ss_drv
  assign pin_in.sck  = pin_out.sck_oe_n ? 1'b1 : pin_out.sck;
  assign pin_in.mosi = pin_out.mosi_oe_n ? 1'b1 : pin_out.mosi;
  assign pin_in.miso = pin_out.miso_oe_n ? peer_miso : pin_out.miso;
  assign pin_in.ss   = pin_out.ss_oe_n ? ss_drv : pin_out.ss;
  assign oe_now = {pin_out.sck_oe_n, pin_out.mosi_oe_n, pin_out.miso_oe_n, pin_out.ss_oe_n};

  spi_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(req), .wb_o(rsp),
    .wait_mode_i(wait_mode), .pin_i(pin_in), .pin_o(pin_out), .irq_o(irq));
  spi_peer_model i_peer (.clk_i(clk_i), .sel_n_i(pin_in.ss), .sck_i(pin_in.sck),
    .mosi_i(pin_in.mosi), .clock_phase_select_i(clock_phase_select), .lsbf_i(lsbf), .tx_byte_i(peer_tx),
    .miso_o(peer_miso), .rx_byte_o(peer_rx));

  // Edges only count while the select line is low
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    sck_q <= pin_in.sck;
    if (pin_in.sck !== sck_q && pin_in.ss === 1'b0) begin
      n_edge <= n_edge + 1;
      t_last <= cyc_n;
      if (n_edge == 0) t_first <= cyc_n;
    end
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t %s: got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [4:0] adr, input logic [7:0] wd);
    @(posedge clk_i);
    req <= '{1'b1, 1'b1, we, adr, 4'h1, {24'h0, wd}};
    do begin
      @(posedge clk_i);
    end while (rsp.ack !== 1'b1);
    chk({rsp.dat[31:8], 8'h00}, 32'h0000_0000, "bus data upper bits");
    rd = rsp.dat[7:0];
    req <= '0;
  endtask

  task automatic rdchk(input logic [4:0] adr, input logic [7:0] exp, input string what);
    wb(1'b0, adr, 8'h00);
    chk({24'h0, rd}, {24'h0, exp}, what);
  endtask

  task automatic poll_rx;
    repeat (200) begin
      wb(1'b0, ADR_STATUS, 8'h00);
      if (rd[7] === 1'b1) break;
    end
    chk({24'h0, rd}, 32'h0000_00A0, "rx full with tx empty");
  endtask

  task automatic xfer(input logic [7:0] d, input logic [7:0] p, input bit stall);
    int e0;
    peer_tx <= p;
    rdchk(ADR_STATUS, 8'h20, "idle status");
    wb(1'b1, ADR_DATA, d);
    n_edge = 0;
    rdchk(ADR_STATUS, 8'h20, "tx empty after load");
    if (stall) begin
      repeat (10) @(posedge clk_i);
      wait_mode <= 1'b1;
      repeat (3) @(posedge clk_i);
      e0 = n_edge;
      repeat (40) @(posedge clk_i);
      chk(n_edge, e0, "clock frozen in wait");
      wait_mode <= 1'b0;
    end
    poll_rx();
    rdchk(ADR_DATA, p, "byte from peer");
    chk({24'h0, peer_rx}, {24'h0, d}, "byte at peer");
    chk(n_edge, 16, "edges with select low");
    chk({31'h0, pin_out.ss}, 32'h0000_0001, "select idle");
    if (!stall) chk(t_last - t_first, 60, "edge spacing");
  endtask

  task automatic finish_test;
    $display("checks %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    rows = '{'{8'h50, 8'h00, 8'h00, 4'h3, 1'b0}, '{8'h52, 8'h00, 8'h00, 4'h3, 1'b0},
             '{8'h52, 8'h10, 8'h10, 4'h2, 1'b0}, '{8'h50, 8'h19, 8'h19, 4'h3, 1'b0},
             '{8'h50, 8'h11, 8'h11, 4'h7, 1'b0}, '{8'h70, 8'h08, 8'h08, 4'h3, 1'b1},
             '{8'h40, 8'h13, 8'h13, 4'hF, 1'b0}, '{8'h42, 8'h10, 8'h10, 4'hF, 1'b0},
             '{8'h00, 8'hFF, 8'h1B, 4'hF, 1'b0}, '{8'h20, 8'h00, 8'h00, 4'hF, 1'b1}};
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk(ADR_CTRL1, 8'h00, "ctrl1 reset");
    rdchk(ADR_CTRL2, 8'h00, "ctrl2 reset");
    rdchk(ADR_BAUD, 8'h00, "baud reset");
    rdchk(ADR_STATUS, 8'h20, "status reset");
    rdchk(5'h14, 8'h00, "unmapped read");
    chk({28'h0, oe_now}, 32'h0000_000F, "pins released at reset");
    $display("test reset done");
    foreach (rows[i]) begin
      wb(1'b1, ADR_CTRL2, rows[i].c2);
      wb(1'b1, ADR_CTRL1, rows[i].c1);
      rdchk(ADR_CTRL1, rows[i].c1, "ctrl1 readback");
      rdchk(ADR_CTRL2, rows[i].c2_rd, "ctrl2 readback");
      chk({28'h0, oe_now}, {28'h0, rows[i].oe_n}, "pin enables");
      chk({31'h0, irq}, {31'h0, rows[i].irq}, "irq level");
    end
    $display("test configuration rows done");
    wb(1'b1, ADR_CTRL1, 8'h00);
    wb(1'b1, ADR_BAUD, 8'h11);
    wb(1'b1, ADR_CTRL2, 8'h10);
    for (int m = 0; m < 8; m++) begin
      clock_phase_select <= m[1];
      lsbf <= m[0];
      wb(1'b1, ADR_CTRL1, 8'h52 | {4'h0, m[2], m[1], 1'b0, m[0]});
      @(posedge clk_i);
      chk({31'h0, pin_out.sck}, {31'h0, m[2]}, "clock idle level");
      xfer(8'hC4 + 8'(m), 8'h5B - 8'(m), 1'b0);
    end
    $display("test clock modes done");
    wb(1'b1, ADR_CTRL2, 8'h12);
    xfer(8'h81, 8'h7E, 1'b1);
    $display("test wait stop done");
    rdchk(ADR_STATUS, 8'h20, "idle status");
    wb(1'b1, ADR_DATA, 8'h0F);
    poll_rx();
    chk({31'h0, irq}, 32'h0000_0000, "rx full polled only");
    wb(1'b1, ADR_DATA, 8'hF0);
    repeat (20) @(posedge clk_i);
    wb(1'b1, ADR_CTRL1, 8'h1F);
    rdchk(ADR_STATUS, 8'h20, "flags after disable");
    chk({28'h0, oe_now}, 32'h0000_000F, "pins released on disable");
    wb(1'b1, ADR_CTRL1, 8'h5F);
    xfer(8'h3A, 8'hC5, 1'b0);
    $display("test abort done");
    wb(1'b1, ADR_CTRL1, 8'hD0);
    ss_drv <= 1'b0;
    repeat (3) @(posedge clk_i);
    rdchk(ADR_STATUS, 8'h30, "mode fault flag");
    rdchk(ADR_CTRL1, 8'hC0, "role dropped on fault");
    chk({31'h0, irq}, 32'h0000_0001, "fault interrupt");
    ss_drv <= 1'b1;
    wb(1'b1, ADR_CTRL1, 8'h40);
    rdchk(ADR_STATUS, 8'h20, "fault cleared");
    ss_drv <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk({31'h0, pin_out.miso_oe_n}, 32'h0000_0000, "selected peripheral drives");
    ss_drv <= 1'b1;
    $display("test fault and select done");
    finish_test();
  end

  // Tests need well under two thousand cycles; this leaves ample margin
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    $display("ERROR %0t watchdog expired", $time);
    finish_test();
  end
endmodule // spi_control_configuration_tb
